// ### inc/rrs_consts.vh
`ifndef RRS_CONSTS_VH
`define RRS_CONSTS_VH

// ****************************************
// timing
// ****************************************
`define RRS_CLK_NS 10
`define RRS_SLOT_NS 8000
`define RRS_SLOT_CYC (`RRS_SLOT_NS / `RRS_CLK_NS)
`define RRS_SETTLE0_US 4300
`define RRS_SETTLE1_US 2300
`define RRS_SETTLE2_US 1300
`define RRS_US_CYC(us) ((us) * 1000 / `RRS_CLK_NS)

// ****************************************
// round-robin slot map
// ****************************************
`define RRS_NUM_SLOTS 24
`define RRS_LAST_SLOT 5'h17
`define RRS_SLOT_DIE 5'h00
`define RRS_SLOT_CELL 5'h05
`define RRS_SLOT_MISC_LO 5'h06
`define RRS_SLOT_MISC_HI 5'h10
`define RRS_SLOT_GPIO 5'h11
`define RRS_MISC_TO_IDX 4'h4

// ****************************************
// result slots
// ****************************************
`define RRS_NUM_RES 14
`define RRS_IDX_DIE 4'h0
`define RRS_IDX_CELL 4'h1
`define RRS_IDX_GPIO 4'hD
`define RRS_RES_DEFAULT 16'h8000
`define RRS_DIE_MAX 16'h00C8
`define RRS_DIE_MIN 16'hFF9C

// ****************************************
// run modes and selects
// ****************************************
`define RRS_MODE_STOP 2'h0
`define RRS_MODE_ONE 2'h1
`define RRS_MODE_CONT 2'h2
`define RRS_MODE_EIGHT 2'h3
`define RRS_EIGHT_CYCLES 4'h8
`define RRS_CSEL_BUSBAR 5'h01
`define RRS_CSEL_CELL_LO 5'h02
`define RRS_CSEL_CELL_HI 5'h11

// ****************************************
// register map, byte addresses
// ****************************************
`define RRS_ADR_CTRL 8'h00
`define RRS_ADR_CONF 8'h04
`define RRS_ADR_STAT 8'h08
`define RRS_ADR_RES 8'h40
`define RRS_ADR_RES_END 8'hAC
`define RRS_CTRL_GO 2
`define RRS_CTRL_THERMISTOR_REFERENCE 3
`define RRS_CONF_RESET 23'h000000
`define RRS_STAT_CMP 2

`endif

// ### logic/rrs_seq.v
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "rrs_consts.vh"
// What this block does
// - cycle 24 slots onto secondary converter
// - each slot 8 us, cycle 192 us
// - slots: die, cell mux, misc, gpio, spares
// - results 16-bit signed, high and low bytes
// - enable resets results to 0x8000, then updates
// - high-byte read freezes low byte until read
// - cells and busbar share one slot
// - hold channel while settling, discard conversions
// - settle field picks 4.3, 2.3, 1.3 ms
// - visit only active selected channels
// - channels one to count are active, count zero all sixteen
// - select: loop, lock cell, lock busbar
// - cell result only when locked and settled
// - otherwise cell result stays 0x8000
// - die temp signed, clamped 200 to -100
// - one gpio slot per cycle, eight cycles
// - gpio order starts input 1 then 3
// - non-converter gpio slot ignored, kept
// - gpio result only when one input locked
// - compare cell result with main result
// - go samples settings, later changes need go
// - run modes stop, one, continuous, eight
// - runs only when active, freezes in sleep
module rrs_seq #(
	parameter [18:0] SETTLE0_CYC = `RRS_US_CYC(`RRS_SETTLE0_US),
	parameter [18:0] SETTLE1_CYC = `RRS_US_CYC(`RRS_SETTLE1_US),
	parameter [18:0] SETTLE2_CYC = `RRS_US_CYC(`RRS_SETTLE2_US),
	parameter [15:0] CMP_TOL = 16'h0010
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_rstn,
	// wishbone slave
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	// converter side
	output reg o_conv_start,
	output reg [4:0] o_slot,
	output reg [4:0] o_cell_chan,
	output reg [2:0] o_gpio_chan,
	input wire [15:0] i_conv_data,
	input wire [15:0] i_main_cell,
	// device state
	input wire i_active_state,
	output reg o_running,
	output reg o_thermistor_ref_enable
);

// ****************************************
// functions
// ****************************************
function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] sel;
	integer b;
	begin
		merge = old;
		for (b = 0; b < 4; b = b + 1) begin
			if (sel[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	end
endfunction

// a count of zero means all sixteen channels
function cell_active;
	input [4:0] ch;
	input [3:0] cnt;
	begin
		cell_active = (ch != 5'h00) &&
			((cnt == 4'h0) || (ch <= {1'b0, cnt}));
	end
endfunction

// interleaved order spreads neighbours over the eight cycles
function [2:0] gpio_of;
	input [2:0] step;
	begin
		gpio_of = {step[1:0], step[2]};
	end
endfunction

function [15:0] die_clamp;
	input [15:0] v;
	begin
		if ($signed(v) > $signed(`RRS_DIE_MAX)) begin
			die_clamp = `RRS_DIE_MAX;
		end else if ($signed(v) < $signed(`RRS_DIE_MIN)) begin
			die_clamp = `RRS_DIE_MIN;
		end else begin
			die_clamp = v;
		end
	end
endfunction

// ****************************************
// bus decode
// ****************************************
wire wb_acc = i_wb_cyc & i_wb_stb & ~o_wb_ack;
wire wb_wr = wb_acc & i_wb_we;
wire wb_rd = wb_acc & ~i_wb_we;
wire in_res = (i_wb_adr >= `RRS_ADR_RES) &&
	(i_wb_adr <= `RRS_ADR_RES_END) && (i_wb_adr[1:0] == 2'h0);
wire [7:0] res_off = i_wb_adr - `RRS_ADR_RES;
wire [3:0] rd_idx = res_off[6:3];
wire rd_lo = res_off[2];
wire ctrl_wr = wb_wr && (i_wb_adr == `RRS_ADR_CTRL) && i_wb_sel[0];
wire go_cmd = ctrl_wr && i_wb_dat[`RRS_CTRL_GO];
wire [1:0] go_mode = i_wb_dat[1:0];
wire go_start = go_cmd && (go_mode != `RRS_MODE_STOP);

// ****************************************
// software registers
// ****************************************
reg [1:0] mode_r;
reg [22:0] conf_r;
reg cmp_fail_r;
reg cmp_set;
wire [31:0] conf_mrg = merge({9'h000, conf_r}, i_wb_dat, i_wb_sel);

always @(posedge i_ref_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		mode_r <= `RRS_MODE_STOP;
		o_thermistor_ref_enable <= 1'b0;
		conf_r <= `RRS_CONF_RESET;
		cmp_fail_r <= 1'b0;
	end else begin
		if (ctrl_wr) begin
			mode_r <= go_mode;
			o_thermistor_ref_enable <= i_wb_dat[`RRS_CTRL_THERMISTOR_REFERENCE];
		end
		if (wb_wr && (i_wb_adr == `RRS_ADR_CONF)) begin
			conf_r <= conf_mrg[22:0];
		end
		// a new mismatch wins over a clear in the same cycle
		if (cmp_set) begin
			cmp_fail_r <= 1'b1;
		end else if (wb_wr && (i_wb_adr == `RRS_ADR_STAT) &&
				i_wb_sel[0] && i_wb_dat[`RRS_STAT_CMP]) begin
			cmp_fail_r <= 1'b0;
		end
	end
end

// ****************************************
// settings sampled at go
// ****************************************
reg [1:0] sh_mode_r;
reg [4:0] sh_csel_r;
reg [3:0] sh_gsel_r;
reg [1:0] sh_settle_r;
reg [3:0] sh_ncell_r;
reg [7:0] sh_gen_r;

always @(posedge i_ref_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		sh_mode_r <= `RRS_MODE_STOP;
		sh_csel_r <= 5'h00;
		sh_gsel_r <= 4'h0;
		sh_settle_r <= 2'h0;
		sh_ncell_r <= 4'h0;
		sh_gen_r <= 8'h00;
	end else if (go_cmd) begin
		sh_mode_r <= go_mode;
		sh_csel_r <= conf_r[4:0];
		sh_gsel_r <= conf_r[8:5];
		sh_settle_r <= conf_r[10:9];
		sh_ncell_r <= conf_r[14:11];
		sh_gen_r <= conf_r[22:15];
	end
end

// ****************************************
// sleep input sync
// ****************************************
reg act_m_r;
reg act_s_r;

always @(posedge i_ref_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		act_m_r <= 1'b0;
		act_s_r <= 1'b0;
	end else begin
		act_m_r <= i_active_state;
		act_s_r <= act_m_r;
	end
end

// ****************************************
// slot sequencer
// ****************************************
reg [9:0] tmr_r;
reg [3:0] rr_r;
reg [2:0] gstep_r;
reg [18:0] setl_r;
wire run_en = o_running & act_s_r;
wire slot_end = run_en && (tmr_r == `RRS_SLOT_CYC - 1);
wire cyc_end = slot_end && (o_slot == `RRS_LAST_SLOT);
wire [3:0] rr_nxt = rr_r + 4'h1;
wire lock_bb = (sh_csel_r == `RRS_CSEL_BUSBAR);
wire lock_cell = (sh_csel_r >= `RRS_CSEL_CELL_LO) &&
	(sh_csel_r <= `RRS_CSEL_CELL_HI);
wire looping = !lock_bb && !lock_cell;
wire [4:0] lock_ch = sh_csel_r - 5'h01;
wire lock_ok = lock_bb ||
	(lock_cell && cell_active(lock_ch, sh_ncell_r));
reg [18:0] settle_lim;
reg [4:0] chan_nxt;

always @* begin
	case (sh_settle_r)
	2'h0: settle_lim = SETTLE0_CYC;
	2'h1: settle_lim = SETTLE1_CYC;
	default: settle_lim = SETTLE2_CYC;
	endcase
end

wire settled = (setl_r >= settle_lim);

// loop order is cell one upward, then the busbar
always @* begin
	if (o_cell_chan == 5'h00) begin
		chan_nxt = 5'h01;
	end else if (!cell_active(o_cell_chan + 5'h01, sh_ncell_r) ||
			(o_cell_chan == 5'h10)) begin
		chan_nxt = 5'h00;
	end else begin
		chan_nxt = o_cell_chan + 5'h01;
	end
end

always @(posedge i_ref_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		o_running <= 1'b0;
		tmr_r <= 10'h000;
		o_slot <= `RRS_SLOT_DIE;
		rr_r <= 4'h0;
		gstep_r <= 3'h0;
		o_gpio_chan <= 3'h0;
		o_cell_chan <= 5'h01;
		setl_r <= 19'h00000;
		o_conv_start <= 1'b0;
	end else begin
		o_conv_start <= go_start | (slot_end & ~cyc_end) |
			(cyc_end & (sh_mode_r == `RRS_MODE_CONT ||
			(sh_mode_r == `RRS_MODE_EIGHT &&
			rr_nxt != `RRS_EIGHT_CYCLES)));
		if (go_cmd) begin
			o_running <= go_start;
			tmr_r <= 10'h000;
			o_slot <= `RRS_SLOT_DIE;
			rr_r <= 4'h0;
			gstep_r <= 3'h0;
			o_gpio_chan <= gpio_of(3'h0);
			setl_r <= 19'h00000;
			if (conf_r[4:0] == `RRS_CSEL_BUSBAR) begin
				o_cell_chan <= 5'h00;
			end else if (conf_r[4:0] >= `RRS_CSEL_CELL_LO &&
					conf_r[4:0] <= `RRS_CSEL_CELL_HI) begin
				o_cell_chan <= conf_r[4:0] - 5'h01;
			end else begin
				o_cell_chan <= 5'h01;
			end
		end else if (run_en) begin
			if (!settled) begin
				setl_r <= setl_r + 19'h00001;
			end
			if (slot_end) begin
				tmr_r <= 10'h000;
				// the channel moves on only after settling
				if (o_slot == `RRS_SLOT_CELL && settled &&
						looping) begin
					o_cell_chan <= chan_nxt;
					setl_r <= 19'h00000;
				end
				if (cyc_end) begin
					o_slot <= `RRS_SLOT_DIE;
					rr_r <= rr_nxt;
					gstep_r <= gstep_r + 3'h1;
					o_gpio_chan <= gpio_of(gstep_r + 3'h1);
					if (sh_mode_r == `RRS_MODE_ONE) begin
						o_running <= 1'b0;
					end else if (sh_mode_r == `RRS_MODE_EIGHT &&
							rr_nxt == `RRS_EIGHT_CYCLES) begin
						o_running <= 1'b0;
					end
				end else begin
					o_slot <= o_slot + 5'h01;
				end
			end else begin
				tmr_r <= tmr_r + 10'h001;
			end
		end
	end
end

// ****************************************
// result capture
// ****************************************
reg upd_en;
reg [3:0] upd_idx;
reg [15:0] upd_val;
wire [16:0] cmp_diff = {i_conv_data[15], i_conv_data} -
	{i_main_cell[15], i_main_cell};
wire [16:0] cmp_abs = cmp_diff[16] ? (17'h00000 - cmp_diff) : cmp_diff;
wire gpio_lock = (sh_gsel_r != 4'h0) && (sh_gsel_r <= 4'h8);

always @* begin
	upd_en = 1'b0;
	upd_idx = `RRS_IDX_DIE;
	upd_val = i_conv_data;
	cmp_set = 1'b0;
	if (slot_end) begin
		if (o_slot == `RRS_SLOT_DIE) begin
			upd_en = 1'b1;
			upd_val = die_clamp(i_conv_data);
		end else if (o_slot == `RRS_SLOT_CELL) begin
			if (settled && lock_ok) begin
				upd_en = 1'b1;
				upd_idx = `RRS_IDX_CELL;
				// busbar check is left to software
				cmp_set = lock_cell &&
					(cmp_abs > {1'b0, CMP_TOL});
			end
		end else if (o_slot >= `RRS_SLOT_MISC_LO &&
				o_slot <= `RRS_SLOT_MISC_HI) begin
			upd_en = 1'b1;
			upd_idx = o_slot[3:0] - `RRS_MISC_TO_IDX;
		end else if (o_slot == `RRS_SLOT_GPIO) begin
			// disabled inputs keep their slot time
			if (gpio_lock && sh_gen_r[o_gpio_chan] &&
					(o_gpio_chan == sh_gsel_r[2:0] - 3'h1)) begin
				upd_en = 1'b1;
				upd_idx = `RRS_IDX_GPIO;
			end
		end
	end
end

reg [15:0] res_r [0:`RRS_NUM_RES-1];
reg [7:0] lo_r [0:`RRS_NUM_RES-1];
reg [`RRS_NUM_RES-1:0] hold_r;
wire hi_rd = wb_rd && in_res && !rd_lo;
wire lo_rd = wb_rd && in_res && rd_lo;
integer k;

always @(posedge i_ref_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		for (k = 0; k < `RRS_NUM_RES; k = k + 1) begin
			res_r[k] <= `RRS_RES_DEFAULT;
			lo_r[k] <= 8'h00;
		end
		hold_r <= {`RRS_NUM_RES{1'b0}};
	end else if (go_start) begin
		for (k = 0; k < `RRS_NUM_RES; k = k + 1) begin
			res_r[k] <= `RRS_RES_DEFAULT;
			lo_r[k] <= 8'h00;
		end
		hold_r <= {`RRS_NUM_RES{1'b0}};
	end else begin
		if (upd_en) begin
			res_r[upd_idx] <= upd_val;
			if (!hold_r[upd_idx] && !(hi_rd && rd_idx == upd_idx)) begin
				lo_r[upd_idx] <= upd_val[7:0];
			end
		end
		if (hi_rd) begin
			hold_r[rd_idx] <= 1'b1;
		end else if (lo_rd) begin
			hold_r[rd_idx] <= 1'b0;
			lo_r[rd_idx] <= (upd_en && upd_idx == rd_idx) ?
				upd_val[7:0] : res_r[rd_idx][7:0];
		end
	end
end

// ****************************************
// bus read and acknowledge
// ****************************************
reg [31:0] rd_val;

always @* begin
	rd_val = 32'h00000000;
	if (in_res) begin
		rd_val = {24'h000000, rd_lo ? lo_r[rd_idx] :
			res_r[rd_idx][15:8]};
	end else begin
		case (i_wb_adr)
		`RRS_ADR_CTRL: begin
			rd_val = {28'h0000000, o_thermistor_ref_enable, 1'b0, mode_r};
		end
		`RRS_ADR_CONF: begin
			rd_val = {9'h000, conf_r};
		end
		`RRS_ADR_STAT: begin
			rd_val = {11'h000, o_cell_chan, gstep_r, 1'b0, rr_r,
				o_slot, cmp_fail_r, settled, o_running};
		end
		default: begin
			rd_val = 32'h00000000;
		end
		endcase
	end
end

always @(posedge i_ref_clk or negedge i_rstn) begin
	if (!i_rstn) begin
		o_wb_ack <= 1'b0;
		o_wb_dat <= 32'h00000000;
	end else begin
		o_wb_ack <= wb_acc;
		if (wb_rd) begin
			o_wb_dat <= rd_val;
		end
	end
end

endmodule

// ### sim/rrs_checker.sv
`timescale 1ns/1ps
// ***
// port checks
// ***
module rrs_checker (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [7:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	input wire o_wb_ack,
	input wire o_conv_start,
	input wire [4:0] o_slot,
	input wire o_running,
	input wire o_thermistor_ref_enable,
	input wire i_active_state
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire wc = req && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[0];
	wire ts = i_wb_dat[3];
	reg [15:0] gap_r;
	// gaps spanning a stop or a freeze are not timed
	reg frz_r;
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			gap_r <= 16'h0000;
			frz_r <= 1'b1;
		end else if (o_conv_start) begin
			gap_r <= 16'h0000;
			frz_r <= !o_running || !i_active_state;
		end else begin
			gap_r <= gap_r + 16'h0001;
			frz_r <= frz_r || !o_running || !i_active_state;
		end
	end
	ack_answer_a: assert property (req |=> o_wb_ack)
		else $error("bus request not acknowledged");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	slot_range_a: assert property (o_slot <= 5'h17)
		else $error("slot out of range");
	slot_step_a: assert property (o_running && $past(o_running) &&
		$changed(o_slot) |-> o_slot == (($past(o_slot) == 5'h17) ?
		5'h00 : $past(o_slot) + 5'h01)) else $error("slot order wrong");
	slot_time_a: assert property (o_conv_start && !frz_r |->
		gap_r == 16'h031F) else $error("slot length wrong");
	go_run_a: assert property (wc && i_wb_dat[2] &&
		i_wb_dat[1:0] != 2'h0 |=> o_running && o_conv_start)
		else $error("go did not start");
	stop_a: assert property (wc && i_wb_dat[2] &&
		i_wb_dat[1:0] == 2'h0 |=> !o_running) else $error("no stop");
	thermistor_reference_a: assert property (wc |=> o_thermistor_ref_enable == $past(ts))
		else $error("reference enable wrong");
	freeze_a: assert property (!i_active_state [*3] |=>
		$stable(o_slot)) else $error("slot moved in sleep");
endmodule

// ### sim/rrs_conv_model.sv
`timescale 1ns/1ps
// ***
// converter and main path model
// ***
module rrs_conv_model (
	// slot in
	input wire [4:0] i_slot,
	input wire i_skew,
	// results out
	output wire [15:0] o_data,
	output wire [15:0] o_main
);
	// 0x0300 plus slot, so a misrouted result shows
	assign o_data = {11'h018, i_slot};
	// main path agrees unless skewed by 0x20
	assign o_main = o_data + {10'h000, i_skew, 5'h00};
endmodule

// ### sim/rrs_seq_tb.sv
`timescale 1ns/1ps
// ***
// bench
// ***
module rrs_seq_tb;
	reg i_ref_clk = 1'b0;
	reg i_rstn = 1'b0;
	reg i_wb_cyc = 1'b0;
	reg i_wb_stb = 1'b0;
	reg i_wb_we = 1'b0;
	reg i_active_state = 1'b1;
	reg skew = 1'b0;
	reg [7:0] i_wb_adr = 8'h00;
	reg [3:0] i_wb_sel = 4'hF;
	reg [31:0] i_wb_dat = 32'h00000000;
	wire [31:0] o_wb_dat;
	wire o_wb_ack, o_conv_start, o_running, o_thermistor_ref_enable;
	wire [4:0] o_slot, o_cell_chan;
	wire [2:0] o_gpio_chan;
	wire [15:0] i_conv_data, i_main_cell;
	integer num_errors = 0;
	integer comparisons = 0;
	integer i, n;
	reg [31:0] rd;
	reg [4:0] s;
	reg [72:0] tab [0:7];
	// short settle counts keep the run small
	rrs_seq #(.SETTLE0_CYC(19'd2000), .SETTLE1_CYC(19'd1200),
		.SETTLE2_CYC(19'd800)) u_dut (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.o_conv_start(o_conv_start), .o_slot(o_slot),
		.o_cell_chan(o_cell_chan), .o_gpio_chan(o_gpio_chan),
		.i_conv_data(i_conv_data), .i_main_cell(i_main_cell),
		.i_active_state(i_active_state), .o_running(o_running),
		.o_thermistor_ref_enable(o_thermistor_ref_enable));
	rrs_conv_model u_conv (.i_slot(o_slot), .i_skew(skew),
		.o_data(i_conv_data), .o_main(i_main_cell));
	always #5 i_ref_clk = ~i_ref_clk;
	task end_of_test;
		begin
			$display("errors %0d compares %0d", num_errors, comparisons);
			if (num_errors == 0 && comparisons > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk_dat(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wb(input we, input [7:0] adr, input [31:0] dat);
		begin
			i_wb_cyc <= 1'b1;
			i_wb_stb <= 1'b1;
			i_wb_we <= we;
			i_wb_adr <= adr;
			i_wb_dat <= dat;
			n = 0;
			@(posedge i_ref_clk);
			while (o_wb_ack !== 1'b1 && n < 100) begin
				@(posedge i_ref_clk);
				n = n + 1;
			end
			if (n >= 100) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0t ack got %h exp %h", $time, o_wb_ack,
					1'b1);
			end
			rd = o_wb_dat;
			i_wb_cyc <= 1'b0;
			i_wb_stb <= 1'b0;
			@(posedge i_ref_clk);
		end
	endtask
	task rdchk(input [7:0] adr, input [31:0] exp);
		begin
			wb(1'b0, adr, 32'h00000000);
			chk_dat(rd, exp);
		end
	endtask
	task run_chk(input [31:0] go);
		begin
			wb(1'b1, 8'h00, go);
			repeat (19400) @(posedge i_ref_clk);
			chk_dat({31'h0, o_running}, 32'h1);
			wb(1'b1, 8'h00, 32'h00000004);
			chk_dat({31'h0, o_running}, 32'h0);
		end
	endtask
	// a hung bus or sequencer ends the run long after the 60k cycles
	initial begin
		#800000;
		num_errors = num_errors + 1;
		end_of_test;
	end
	initial begin
		tab[0] = {1'b0, 8'h00, 32'h0, 32'h0};
		tab[1] = {1'b0, 8'h04, 32'h0, 32'h0};
		tab[2] = {1'b0, 8'h40, 32'h0, 32'h80};
		tab[3] = {1'b0, 8'h44, 32'h0, 32'h0};
		tab[4] = {1'b0, 8'hA8, 32'h0, 32'h80};
		tab[5] = {1'b0, 8'hFC, 32'h0, 32'h0};
		tab[6] = {1'b1, 8'h04, 32'h8421, 32'h0};
		tab[7] = {1'b0, 8'h04, 32'h0, 32'h8421};
		repeat (3) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		@(posedge i_ref_clk);
		for (i = 0; i < 8; i = i + 1) begin
			wb(tab[i][72], tab[i][71:64], tab[i][63:32]);
			if (!tab[i][72])
				chk_dat(rd, tab[i][31:0]);
		end
		$display("register table done");
		wb(1'b1, 8'h00, 32'h00000008);
		chk_dat({31'h0, o_thermistor_ref_enable}, 32'h1);
		repeat (100) @(posedge i_ref_clk);
		wb(1'b1, 8'h00, 32'h0000000D);
		n = 0;
		while (o_running === 1'b1 && n < 25000) begin
			@(posedge i_ref_clk);
			n = n + 1;
		end
		chk_dat({31'h0, n > 19100 && n < 19300}, 32'h1);
		rdchk(8'h40, 32'h00);
		rdchk(8'h44, 32'hC8);
		rdchk(8'h48, 32'h03);
		rdchk(8'h4C, 32'h05);
		rdchk(8'h54, 32'h06);
		rdchk(8'hAC, 32'h11);
		rdchk(8'h08, 32'h00002102);
		$display("single cycle run done");
		wb(1'b1, 8'h04, 32'h007F9406);
		wb(1'b1, 8'h00, 32'h00000006);
		repeat (10000) @(posedge i_ref_clk);
		i_active_state <= 1'b0;
		repeat (10) @(posedge i_ref_clk);
		s = o_slot;
		repeat (1000) @(posedge i_ref_clk);
		chk_dat({27'h0, o_slot}, {27'h0, s});
		i_active_state <= 1'b1;
		repeat (9400) @(posedge i_ref_clk);
		chk_dat({31'h0, o_running}, 32'h1);
		chk_dat({29'h0, o_gpio_chan}, 32'h2);
		chk_dat({27'h0, o_cell_chan}, 32'h5);
		wb(1'b1, 8'h00, 32'h00000004);
		rdchk(8'h48, 32'h80);
		rdchk(8'hA8, 32'h80);
		$display("continuous run done");
		wb(1'b1, 8'h04, 32'h007F9402);
		skew <= 1'b1;
		run_chk(32'h00000007);
		rdchk(8'h48, 32'h03);
		rdchk(8'h4C, 32'h05);
		wb(1'b0, 8'h08, 32'h00000000);
		chk_dat(rd & 32'h4, 32'h4);
		wb(1'b1, 8'h08, 32'h00000004);
		wb(1'b0, 8'h08, 32'h00000000);
		chk_dat(rd & 32'h4, 32'h0);
		$display("eight cycle run done");
		end_of_test;
	end
endmodule
bind rrs_seq rrs_checker u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
	.i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_ack(o_wb_ack), .o_conv_start(o_conv_start), .o_slot(o_slot),
	.o_running(o_running), .o_thermistor_ref_enable(o_thermistor_ref_enable),
	.i_active_state(i_active_state));
